// file: src/srmc_top.sv
// reset sequencer and boot strap decoder for the switch
// assumes arst_n is the power-on reset; straps and reset pins arrive asynchronously
`timescale 1ns/10ps

// Summary of operation
// - merge strap low merges ports 12/13 x8
// - port 13 lanes become lanes 4-7
// - merge strap high keeps two x4 ports
// - undriven merge strap means merge requested
// - fundamental reset holds all logic in reset
// - reset hold stops after procedure, SMBus alive
// - hold exits when SMBus clears hold bit
// - code 0 single, code 1 with EEPROM
// - code 8 port 0 upstream, port 2 off
// - codes A/B EEPROM with chosen upstream port
// - codes C/D multi-partition, D with EEPROM
module srmc_top #(
	parameter int PROC_CYC = srmc_pkg::RESET_PROC_CYC
) (
	input wire logic mclk, // core clock, 25 MHz
	input wire logic arst_n, // power-on reset, active low
	input wire logic fundamental_reset_n, // global fundamental reset pin
	input wire logic reset_hold, // reset-hold strap pin
	input wire logic [3:0] switch_config_select, // switch-mode straps
	input wire logic port_pair_merge_n, // port 12/13 merge strap, pulled low
	input wire logic hold_bit_clear, // SMBus master clears hold bit, pulse
	output logic core_reset_n, // reset to switch core, active low
	output logic smbus_enable, // master and slave SMBus active
	output logic hold_bit, // reset-hold bit of switch control register
	output logic proc_running, // reset procedure in progress
	output logic [3:0] mode_latched, // captured switch-mode code
	output logic port12_x8, // ports 12 and 13 merged
	output logic port13_enable, // port 13 runs as its own port
	output logic [2:0] port13_lane_base, // first port 12 lane fed by port 13
	output logic [2:0] port12_width_lanes, // lane count of port 12 minus one
	output logic multi_partition, // multi-partition mode
	output logic eeprom_init, // initialise from serial EEPROM
	output logic port0_upstream, // port 0 is upstream
	output logic port2_upstream, // port 2 is upstream
	output logic port0_disable, // port 0 disabled
	output logic port2_disable, // port 2 disabled
	output logic mode_reserved // strap code is reserved
);
	// strap decode: one flag for each property of the selected switch mode
	typedef struct packed {
		logic reserved; // code outside the defined set
		logic multi; // multi-partition operation
		logic eeprom; // load from serial EEPROM
		logic p0_up; // port 0 is upstream
		logic p2_up; // port 2 is upstream
		logic p0_off; // port 0 disabled
		logic p2_off; // port 2 disabled
	} srmc_dec_t;

	// every register of the sequencer, filled by one process and stored by another; the pin synchroniser keeps its own
	typedef struct packed {
		srmc_pkg::srmc_state_t st; // sequencer state
		logic [srmc_pkg::CNT_W-1:0] cnt; // cycles spent in the reset procedure
		logic hold; // reset-hold bit
		logic [3:0] mode; // captured switch-mode code
		logic merge_n; // captured merge strap
		logic core_rst_n; // core reset, active low
		srmc_dec_t dec; // decoded mode flags
	} srmc_regs_t;

	srmc_regs_t r_q;
	srmc_regs_t r_d;
	logic [6:0] pins_s;
	logic perst_s;
	logic hold_s;
	logic [3:0] mode_s;
	logic merge_s;

	// ================================================================
	// pin synchronisers; the merge strap resets low like its pull-down
	// the mode bits cross as a bus, which is safe only because they sit still during reset
	srmc_sync #(
		.W(7),
		.RST_VAL(7'h00)
	) u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.din({fundamental_reset_n, reset_hold, switch_config_select, port_pair_merge_n}),
		.dout(pins_s)
	);

	assign perst_s = pins_s[6];
	assign hold_s = pins_s[5];
	assign mode_s = pins_s[4:1];
	assign merge_s = pins_s[0];

	// ================================================================
	// mode decode; a reserved code only raises its flag and leaves a plain single partition
	function automatic srmc_dec_t decode_mode(input logic [3:0] m);
		srmc_dec_t v;
		v = '0;
		unique case (m)
			srmc_pkg::MODE_SINGLE: begin
				v = '0;
			end
			srmc_pkg::MODE_SINGLE_EE: begin
				v.eeprom = 1'b1;
			end
			srmc_pkg::MODE_SINGLE_P0UP: begin
				v.p0_up = 1'b1;
				v.p2_off = 1'b1;
			end
			srmc_pkg::MODE_SINGLE_P2UP: begin
				v.p2_up = 1'b1;
				v.p0_off = 1'b1;
			end
			srmc_pkg::MODE_SINGLE_EE_P0UP: begin
				v.eeprom = 1'b1;
				v.p0_up = 1'b1;
				v.p2_off = 1'b1;
			end
			srmc_pkg::MODE_SINGLE_EE_P2UP: begin
				v.eeprom = 1'b1;
				v.p2_up = 1'b1;
				v.p0_off = 1'b1;
			end
			srmc_pkg::MODE_MULTI: begin
				v.multi = 1'b1;
			end
			srmc_pkg::MODE_MULTI_EE: begin
				v.multi = 1'b1;
				v.eeprom = 1'b1;
			end
			default: begin
				v.reserved = 1'b1; // codes 2 to 7, E and F
			end
		endcase
		return v;
	endfunction

	// ================================================================
	// next-state logic of the sequencer
	// straps are taken once, on the edge that leaves reset, so later strap moves change nothing
	// a hold clear outside the hold state is ignored; the reset pin wins over state, counter and core reset, but a clear in hold still drops the hold bit
	always_comb begin
		r_d = r_q;
		unique case (r_q.st)
			srmc_pkg::SQ_RESET: begin
				r_d.core_rst_n = 1'b0;
				r_d.hold = hold_s;
				r_d.cnt = '0;
				if (perst_s) begin
					r_d.mode = mode_s;
					r_d.merge_n = merge_s;
					r_d.dec = decode_mode(mode_s);
					r_d.st = srmc_pkg::SQ_PROC;
				end
			end
			srmc_pkg::SQ_PROC: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (32'(r_q.cnt) + 1 >= PROC_CYC) begin
					if (r_q.hold) begin
						r_d.st = srmc_pkg::SQ_HOLD;
					end else begin
						r_d.st = srmc_pkg::SQ_RUN;
						r_d.core_rst_n = 1'b1;
					end
				end
			end
			srmc_pkg::SQ_HOLD: begin
				if (hold_bit_clear) begin
					r_d.hold = 1'b0;
					r_d.st = srmc_pkg::SQ_RUN;
					r_d.core_rst_n = 1'b1;
				end
			end
			srmc_pkg::SQ_RUN: begin
				r_d.core_rst_n = 1'b1;
			end
		endcase
		// fundamental reset overrides every state
		if (!perst_s) begin
			r_d.st = srmc_pkg::SQ_RESET;
			r_d.core_rst_n = 1'b0;
			r_d.cnt = '0;
		end
	end

	// ================================================================
	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r_q.st <= srmc_pkg::SQ_RESET;
			r_q.cnt <= '0;
			r_q.hold <= 1'b0;
			r_q.mode <= srmc_pkg::MODE_RST;
			r_q.merge_n <= srmc_pkg::MERGE_N_RST;
			r_q.core_rst_n <= 1'b0;
			r_q.dec <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// ================================================================
	// outputs
	assign core_reset_n = r_q.core_rst_n;
	assign smbus_enable = (r_q.st == srmc_pkg::SQ_HOLD) || (r_q.st == srmc_pkg::SQ_RUN);
	assign hold_bit = r_q.hold;
	assign proc_running = (r_q.st == srmc_pkg::SQ_PROC);
	assign mode_latched = r_q.mode;
	assign port12_x8 = ~r_q.merge_n;
	assign port13_enable = r_q.merge_n;
	assign port13_lane_base = srmc_pkg::UPPER_LANE_BASE;
	assign port12_width_lanes = r_q.merge_n ? 3'(srmc_pkg::LANES_PER_PORT - 1)
		: 3'(2 * srmc_pkg::LANES_PER_PORT - 1);
	assign mode_reserved = r_q.dec.reserved;
	assign multi_partition = r_q.dec.multi;
	assign eeprom_init = r_q.dec.eeprom;
	assign port0_upstream = r_q.dec.p0_up;
	assign port2_upstream = r_q.dec.p2_up;
	assign port2_disable = r_q.dec.p2_off;
	assign port0_disable = r_q.dec.p0_off;
endmodule

// file: src/srmc_pkg.sv
// package for the switch reset and mode configuration block
// assumes a single 25 MHz core clock domain
package srmc_pkg;
	// switch-mode strap codes
	localparam logic [3:0] MODE_SINGLE = 4'h0;
	localparam logic [3:0] MODE_SINGLE_EE = 4'h1;
	localparam logic [3:0] MODE_SINGLE_P0UP = 4'h8;
	localparam logic [3:0] MODE_SINGLE_P2UP = 4'h9;
	localparam logic [3:0] MODE_SINGLE_EE_P0UP = 4'hA;
	localparam logic [3:0] MODE_SINGLE_EE_P2UP = 4'hB;
	localparam logic [3:0] MODE_MULTI = 4'hC;
	localparam logic [3:0] MODE_MULTI_EE = 4'hD;
	// reset values
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic MERGE_N_RST = 1'b0;
	// lanes of one unmerged x4 port and the base of port 13 lanes in port 12
	localparam int LANES_PER_PORT = 4;
	localparam logic [2:0] UPPER_LANE_BASE = 3'h4;
	// reset sequence: cycles the reset procedure takes after release
	localparam int RESET_PROC_NS = 400;
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_PROC_CYC = (RESET_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	// sequencer states
	typedef enum logic [1:0] {
		SQ_RESET = 2'b00,
		SQ_PROC = 2'b01,
		SQ_HOLD = 2'b10,
		SQ_RUN = 2'b11
	} srmc_state_t;
endpackage

// file: src/srmc_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes the inputs come from outside the mclk domain
`timescale 1ns/10ps
module srmc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk, // core clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic [W-1:0] din, // asynchronous levels
	output logic [W-1:0] dout // synchronised levels
);
	logic [W-1:0] meta_q;

	// ================================================================
	// two-stage capture
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// file: verif/srmc_board.sv
// board straps and smbus master model
// assumes the bench calls its tasks; pins change on falling mclk
`timescale 1ns/10ps
module srmc_board (
	input wire logic mclk, // core clock
	output logic fundamental_reset_n, // reset pin
	output logic reset_hold, // hold strap
	output logic [3:0] switch_config_select, // mode straps
	output logic port_pair_merge_n, // merge strap, pulled low
	output logic hold_bit_clear // smbus clear pulse
);
	// ==========
	// pins start low: reset held, merge strap at its pull-down
	initial {fundamental_reset_n, reset_hold, switch_config_select, port_pair_merge_n, hold_bit_clear} = '0;
	// straps set only while reset is low, legal codes only
	task automatic boot(input logic [3:0] s, input logic m, input logic h);
		@(negedge mclk) fundamental_reset_n = 1'b0;
		switch_config_select = s;
		port_pair_merge_n = m;
		reset_hold = h;
		repeat (4) @(negedge mclk);
		fundamental_reset_n = 1'b1;
	endtask
	// one-cycle write clearing the hold bit
	task automatic clear();
		@(negedge mclk) hold_bit_clear = 1'b1;
		@(negedge mclk) hold_bit_clear = 1'b0;
	endtask
	// straps moved after release on purpose; the block must ignore them until the next reset
	task automatic move(input logic [3:0] s, input logic m, input logic h);
		@(negedge mclk) switch_config_select = s;
		port_pair_merge_n = m;
		reset_hold = h;
	endtask
	// reset pin alone, for a mid-run reset and its release
	task automatic set_reset(input logic v);
		@(negedge mclk) fundamental_reset_n = v;
	endtask
endmodule

// file: verif/srmc_properties.sv
// checker for the reset sequencer and strap decode
// assumes it is bound into srmc_top, one mclk domain
`timescale 1ns/10ps
module srmc_properties (
	input wire logic mclk, // clock
	input wire logic arst_n, // reset
	input wire logic fundamental_reset_n, // pin
	input wire logic hold_bit_clear, // clear
	input wire logic core_reset_n, // core reset
	input wire logic smbus_enable, // smbus on
	input wire logic hold_bit, // hold
	input wire logic [3:0] mode_latched, // code
	input wire logic port12_x8, // merged
	input wire logic port13_enable, // split
	input wire logic [2:0] port13_lane_base, // base
	input wire logic [2:0] port12_width_lanes, // width
	input wire logic multi_partition, // multi
	input wire logic eeprom_init, // eeprom
	input wire logic port0_upstream, // p0 up
	input wire logic port2_upstream, // p2 up
	input wire logic port0_disable, // p0 off
	input wire logic port2_disable, // p2 off
	input wire logic proc_running, // procedure
	input wire logic mode_reserved // reserved code
);
	// ==========
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_low; !fundamental_reset_n [*4]; endsequence
	sequence s_clr; smbus_enable && !core_reset_n && hold_bit_clear && $past(fundamental_reset_n)
		&& $past(fundamental_reset_n, 2); endsequence
	property p_shape; port13_enable == !port12_x8 && port13_lane_base == 3'h4
		&& port12_width_lanes == (port12_x8 ? 3'h7 : 3'h3); endproperty
	a_shape: assert property (p_shape) else $error("port shape wrong");
	property p_rst; s_low |-> !core_reset_n && !smbus_enable; endproperty
	a_rst: assert property (p_rst) else $error("core not in reset");
	property p_hold; smbus_enable && hold_bit |-> !core_reset_n; endproperty
	a_hold: assert property (p_hold) else $error("hold left early");
	property p_clr; s_clr |=> core_reset_n && !hold_bit; endproperty
	a_clr: assert property (p_clr) else $error("clear ignored");
	property p_ee; core_reset_n |-> eeprom_init == (mode_latched inside {4'h1, 4'hA, 4'hB, 4'hD}); endproperty
	a_ee: assert property (p_ee) else $error("eeprom flag wrong");
	property p_up; core_reset_n |-> port0_upstream == (mode_latched inside {4'h8, 4'hA}) && port2_disable == port0_upstream
		&& port2_upstream == (mode_latched inside {4'h9, 4'hB}) && port0_disable == port2_upstream; endproperty
	a_up: assert property (p_up) else $error("upstream wrong");
	property p_multi; core_reset_n |-> multi_partition == (mode_latched[3:1] == 3'b110); endproperty
	a_multi: assert property (p_multi) else $error("partition wrong");
	property p_keep; core_reset_n && $past(core_reset_n) |-> $stable(mode_latched); endproperty
	a_keep: assert property (p_keep) else $error("mode moved");
	sequence s_done; $fell(proc_running) && hold_bit; endsequence
	property p_proc; proc_running |-> !core_reset_n && !smbus_enable; endproperty
	a_proc: assert property (p_proc) else $error("core left reset during procedure");
	property p_done; s_done |-> !core_reset_n && (smbus_enable || !$past(fundamental_reset_n, 3)); endproperty
	a_done: assert property (p_done) else $error("hold not kept after procedure");
	property p_rsv; core_reset_n |-> mode_reserved
		== !(mode_latched inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD}); endproperty
	a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
endmodule
bind srmc_top srmc_properties srmc_properties_i (.*);

// file: verif/tb_srmc_top.sv
// self-checking bench for the reset sequencer and strap decode
// assumes srmc_board drives the pins and the checker is bound
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_srmc_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic fundamental_reset_n, reset_hold, port_pair_merge_n, hold_bit_clear, core_reset_n, smbus_enable, hold_bit;
	logic proc_running, port12_x8, port13_enable, multi_partition, eeprom_init, mode_reserved;
	logic port0_upstream, port2_upstream, port0_disable, port2_disable;
	logic [3:0] switch_config_select, mode_latched;
	logic [2:0] port13_lane_base, port12_width_lanes;
	int fail_count = 0;
	int n_tests = 0;
	wire [13:0] dec = {port12_x8, port13_enable, port13_lane_base, port12_width_lanes, multi_partition, eeprom_init,
		port0_upstream, port2_upstream, port0_disable, port2_disable};
	// ==========
	initial forever #20 mclk = ~mclk;
	srmc_board srmc_board_i (.*);
	srmc_top #(.PROC_CYC(2)) srmc_top_i (.*);
	// decode of a legal code and merge strap
	function automatic logic [13:0] exp_dec(input logic [3:0] c, input logic m);
		exp_dec = {!m, m, 3'h4, m ? 3'h3 : 3'h7, c[3:1] == 3'b110, c inside {4'h1, 4'hA, 4'hB, 4'hD},
			c inside {4'h8, 4'hA}, c inside {4'h9, 4'hB}, c inside {4'h9, 4'hB}, c inside {4'h8, 4'hA}};
	endfunction
	task automatic report_and_stop();
		if (fail_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// bounded wait for run, or for hold when h is set
	task automatic wait_up(input logic h);
		int i;
		for (i = 0; i < 50 && (h ? smbus_enable : core_reset_n) !== 1'b1; i++) @(negedge mclk);
		if (i == 50) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	// every legal code, merge strap alternating
	task automatic t_modes();
		logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
		foreach (codes[k]) begin
			srmc_board_i.boot(codes[k], k[0], 1'b0);
			wait_up(1'b0);
			`CHK(mode_latched, codes[k])
			`CHK(dec, exp_dec(codes[k], k[0]))
			`CHK({mode_reserved, smbus_enable, proc_running}, 3'b010)
		end
	endtask
	// stays in reset after the procedure until the clear
	task automatic t_hold();
		srmc_board_i.boot(4'hC, 1'b1, 1'b1);
		repeat (3) @(negedge mclk);
		`CHK({proc_running, core_reset_n}, 2'b10)
		wait_up(1'b1);
		repeat (20) @(negedge mclk);
		`CHK({core_reset_n, hold_bit, proc_running, smbus_enable}, 4'b0101)
		srmc_board_i.clear();
		`CHK({core_reset_n, hold_bit, smbus_enable}, 3'b101)
	endtask
	// straps moved after release, then reset in run
	task automatic t_late();
		srmc_board_i.move(4'h1, 1'b0, 1'b0);
		repeat (5) @(negedge mclk);
		`CHK({mode_latched, port12_x8}, 5'h18)
		srmc_board_i.set_reset(1'b0);
		repeat (4) @(negedge mclk);
		`CHK({core_reset_n, smbus_enable}, 2'b00)
		srmc_board_i.set_reset(1'b1);
		wait_up(1'b0);
		`CHK({mode_latched, port12_x8}, 5'h03)
	endtask
	initial begin
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		t_modes();
		t_hold();
		t_late();
		report_and_stop();
	end
endmodule
